// ### hdl/srx_pkg.sv
// Purpose: Shared constants and types for the receive lock, mute and
//          pattern test block.
// Assumes: One core clock at 100 MHz; words are 16 bits wide.
// Notes:   Every offset, seed, count and tolerance is named here once.
package srx_pkg;
	// Parallel word width on both the transmit and receive side
	localparam int WORD_W       = 16;
	// Pattern polynomial x^23 + x^18 + 1
	localparam int PRBS_ORDER   = 23;
	localparam int PRBS_TAP     = 18;
	// Error-free words in a row before the checker claims sync
	localparam int SYNC_RUN     = 8;
	// Pin-to-output transmit latency in core clock cycles (18 to 20)
	localparam int TX_LAT_MIN   = 18;
	localparam int TX_LAT_CYC   = 19;
	// Cycles used by the pin synchroniser and the output flop
	localparam int TX_FIXED_CYC = 3;
	// Frequency comparison: window in reference edges and tolerance
	localparam int FREQ_WIN     = 4000;
	localparam int PPM_TOL      = 500;
	localparam int PPM_SCALE    = 1000000;
	// Reset values
	localparam logic [WORD_W-1:0]     WORD_RST  = 16'h0000;
	localparam logic [PRBS_ORDER-1:0] PRBS_SEED = 23'h7fffff;

	// Clock recovery loop states
	typedef enum logic [1:0] {
		SRX_REF_TRAIN,
		SRX_DATA_ACQ,
		SRX_LOCKED
	} srx_lock_e;
endpackage

// ### hdl/srx_prbs_if.sv
// Purpose: Carrier between the top level and the pattern engine.
// Assumes: Both ends sit on core_clk.
// Notes:   Error flag and generator word come back from flip-flops.
`timescale 1ns/1ns
interface srx_prbs_if;
	logic        en;        // Pattern test on (synchronised)
	logic        clr_n;     // Error clear, active low (synchronised)
	logic        rx_valid;  // Receive word present this cycle
	logic [15:0] rx_word;   // Receive word to check
	logic [15:0] gen_word;  // Generated transmit word
	logic        err;       // Pattern error flag

	modport top  (output en, clr_n, rx_valid, rx_word,
	              input gen_word, err);
	modport prbs (input en, clr_n, rx_valid, rx_word,
	              output gen_word, err);
endinterface

// ### hdl/srx_prbs.sv
// Purpose: Pattern generator and self-seeding checker, 16 bits a cycle.
// Assumes: Bit 0 of a word is the newest bit of the sequence.
// Notes:   Checker reseeds itself from the received stream on a miss.
`timescale 1ns/1ns
module srx_prbs
	import srx_pkg::*;
(
	input  wire logic   core_clk,
	input  wire logic   rst_b,
	srx_prbs_if.prbs    pif
);
	typedef logic [PRBS_ORDER-1:0] srx_state_t;

	srx_state_t            gen;          // Generator state
	srx_state_t            next_gen;
	srx_state_t            chk;          // Checker prediction state
	srx_state_t            next_chk;
	logic [WORD_W-1:0]     gen_word;     // Registered generator word
	logic [WORD_W-1:0]     next_gen_word;
	logic [WORD_W-1:0]     prev;         // Last received word
	logic [WORD_W-1:0]     next_prev;
	logic [3:0]            run;          // Good words in a row
	logic [3:0]            next_run;
	logic                  err;
	logic                  next_err;
	logic [PRBS_ORDER+WORD_W-1:0] step; // {state, word} after 16 bits
	logic [PRBS_ORDER+WORD_W-1:0] pred;
	logic                  in_sync;

	// Sixteen LFSR steps; returns the new state above the produced word
	function automatic logic [PRBS_ORDER+WORD_W-1:0] adv16(
		input srx_state_t s_in);
		srx_state_t        s;
		logic [WORD_W-1:0] w;
		logic              b;
		s = s_in;
		w = WORD_RST;
		for (int i = 0; i < WORD_W; i++) begin
			b = s[PRBS_ORDER-1] ^ s[PRBS_TAP-1];
			s = {s[PRBS_ORDER-2:0], b};
			w = {w[WORD_W-2:0], b};
		end
		return {s, w};
	endfunction

	assign pif.gen_word = gen_word;
	assign pif.err      = err;
	assign in_sync      = (run == 4'(SYNC_RUN));

	////////////////////////////////////////////////////////////////////
	// Next-state logic for generator and checker
	always_comb begin
		step          = adv16(gen);
		pred          = adv16(chk);
		next_gen      = gen;
		next_gen_word = gen_word;
		next_chk      = chk;
		next_prev     = prev;
		next_run      = run;
		// Generator runs only in pattern test
		if (pif.en) begin
			next_gen      = step[PRBS_ORDER+WORD_W-1:WORD_W];
			next_gen_word = step[WORD_W-1:0];
		end
		// Checker enabled by the same pattern test control
		if (!pif.en) begin
			next_run = 4'h0;
		end else if (pif.rx_valid) begin
			next_prev = pif.rx_word;
			if (pif.rx_word == pred[WORD_W-1:0]) begin
				next_chk = pred[PRBS_ORDER+WORD_W-1:WORD_W];
				// Count up to the sync run, then hold
				if (!in_sync)
					next_run = run + 4'h1;
			end else begin
				// Reseed from the last 23 received bits
				next_chk = {prev[PRBS_ORDER-WORD_W-1:0], pif.rx_word};
				next_run = 4'h0;
			end
		end
		// Out of sync sets the flag; a held error drops only on clear.
		// Setting wins over a clear in the same cycle.
		if (!in_sync)
			next_err = 1'b1;
		else if (!pif.clr_n)
			next_err = 1'b0;
		else
			next_err = err;
	end

	// State registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gen      <= PRBS_SEED;
			gen_word <= WORD_RST;
			chk      <= PRBS_SEED;
			prev     <= WORD_RST;
			run      <= 4'h0;
			err      <= 1'b1;
		end else begin
			gen      <= next_gen;
			gen_word <= next_gen_word;
			chk      <= next_chk;
			prev     <= next_prev;
			run      <= next_run;
			err      <= next_err;
		end
	end
endmodule

// ### hdl/srx_top.sv
// Purpose: Receive lock and mute control, pattern test and transmit
//          through path of a line transceiver, at word level.
// Assumes: Word-rate clocks arrive as levels; deserialiser is on core_clk.
// Notes:   The rules that this block keeps are listed below.
// Behaviour
// - Transmit pin to output within 18-20 cycles
// - FEC reference selects 166.63 Mbps word rate
// - Pattern test sends 2^23-1 sequence
// - Pattern test also enables the checker
// - Checker out of sync drives error one
// - Clear held low resets latched error
// - Error low once sequence found; here it stays one until clear is held low after sync
// - Serial remote loop off in pattern test
// - Word output with recovered divided clock
// - Restart loop from reference on init, loss
// - Train on reference first, then data
// - Off by 500 ppm: lose lock
// - Keep parallel clock from reference when unlocked
// - Signal detect inactive declares loss of lock
// - Mute data on loss or disable low
// - Signal present and in tolerance: relock
// - Host parallel loop with clean timing
// - Loss of signal is detect xor polarity
`timescale 1ns/1ns
module srx_top
	import srx_pkg::*;
#(
	parameter int FREQ_WIN_P = FREQ_WIN,   // Reference edges per window
	parameter int TX_LAT_P   = TX_LAT_CYC  // Transmit latency in cycles
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic [WORD_W-1:0] tx_parallel_in,
	output logic      [WORD_W-1:0] tx_serial_out,
	output logic                   tx_rate_fec,
	input  wire logic              fec_ref_select,
	input  wire logic [WORD_W-1:0] rx_serial_in,
	input  wire logic              rx_serial_valid,
	output logic                   rx_serial_ready,
	output logic      [WORD_W-1:0] rx_parallel_out,
	output logic                   rx_parallel_valid,
	input  wire logic              rx_parallel_ready,
	output logic                   rx_parallel_clock_out,
	output logic                   rx_pclk_on_ref,
	input  wire logic              ref_clock_a,
	input  wire logic              ref_clock_b,
	input  wire logic              recovered_div_clk,
	input  wire logic              optical_signal_detect_in,
	input  wire logic              signal_detect_polarity,
	input  wire logic              rx_data_disable_n,
	output logic                   loss_of_signal_state,
	output logic                   recovery_lock_out,
	input  wire logic              pattern_test_enable,
	input  wire logic              pattern_error_clear,
	output logic                   pattern_error_flag,
	output logic                   serial_remote_loop_active,
	input  wire logic              host_mode,
	input  wire logic              parallel_remote_loop_select,
	input  wire logic              dejitter_loop_timing,
	output logic                   parallel_loop_active,
	output logic                   loop_timing_clean
);
	localparam int SYN_W   = WORD_W + 12;           // Pins to synchronise
	localparam int PIPE_D  = TX_LAT_P - TX_FIXED_CYC; // Delay line depth
	localparam int TOL_CNT = FREQ_WIN_P * PPM_TOL / PPM_SCALE;
	localparam int CNT_W   = $clog2(2 * FREQ_WIN_P + 1);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(FREQ_WIN_P - 1);
	localparam logic [CNT_W-1:0] REC_LO   = CNT_W'(FREQ_WIN_P - TOL_CNT);
	localparam logic [CNT_W-1:0] REC_HI   = CNT_W'(FREQ_WIN_P + TOL_CNT);
	localparam logic [CNT_W-1:0] CNT_MAX  = '1;

	////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	logic [SYN_W-1:0] syn1;      // First stage, read only by syn2
	logic [SYN_W-1:0] syn2;      // Safe copy of the pins
	logic [2:0]       clk_hist;  // Previous ref a, ref b, recovered
	logic [WORD_W-1:0] tx_s;     // Synchronised transmit word
	logic fec_s, sd_s, pol_s, dis_n_s, pt_s, clr_s, rlp_s, host_s;
	logic dej_s, refa_s, refb_s, rec_s;
	logic ref_s, ref_prev, ref_edge, rec_edge;

	// Two flops on the transmit word and control pins; receive data, handshake and the disable clear of out_d skip them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			syn1     <= '0;
			syn2     <= '0;
			clk_hist <= 3'h0;
		end else begin
			syn1     <= {tx_parallel_in, fec_ref_select,
			             optical_signal_detect_in, signal_detect_polarity,
			             rx_data_disable_n, pattern_test_enable,
			             pattern_error_clear, parallel_remote_loop_select,
			             host_mode, dejitter_loop_timing, ref_clock_a,
			             ref_clock_b, recovered_div_clk};
			syn2     <= syn1;
			clk_hist <= syn2[2:0];
		end
	end

	assign {tx_s, fec_s, sd_s, pol_s, dis_n_s, pt_s, clr_s, rlp_s,
	        host_s, dej_s, refa_s, refb_s, rec_s} = syn2;
	// The FEC selection also picks which reference trains the loop
	assign ref_s    = fec_s ? refb_s : refa_s;
	assign ref_prev = fec_s ? clk_hist[1] : clk_hist[2];
	assign ref_edge = ref_s & ~ref_prev;
	assign rec_edge = rec_s & ~clk_hist[0];

	////////////////////////////////////////////////////////////////////
	// Loss of signal and clock recovery lock

	srx_lock_e        state;       // Loop state
	srx_lock_e        next_state;
	logic [CNT_W-1:0] ref_cnt;     // Reference edges in this window
	logic [CNT_W-1:0] next_ref_cnt;
	logic [CNT_W-1:0] rec_cnt;     // Recovered edges in this window
	logic [CNT_W-1:0] next_rec_cnt;
	logic             lock;
	logic             next_lock;
	logic             los;
	logic             next_los;
	logic             pclk;
	logic             next_pclk;
	logic             on_ref;
	logic             next_on_ref;
	logic             los_now;
	logic             win_end;
	logic             in_tol;

	assign los_now = sd_s ^ pol_s;
	assign win_end = ref_edge && (ref_cnt == WIN_LAST);
	// A window of FREQ_WIN reference edges, +-TOL_CNT is 500 ppm
	assign in_tol  = (rec_cnt >= REC_LO) && (rec_cnt <= REC_HI);

	// Window counters and loop state
	always_comb begin
		next_state   = state;
		next_lock    = lock;
		next_ref_cnt = ref_cnt;
		next_rec_cnt = rec_cnt;
		next_los     = los_now;
		// Count both clocks; the recovered count saturates
		if (ref_edge)
			next_ref_cnt = win_end ? '0 : ref_cnt + 1'b1;
		// An edge on the boundary opens the next window, else it is lost
		if (win_end)
			next_rec_cnt = {{(CNT_W-1){1'b0}}, rec_edge};
		else if (rec_edge && rec_cnt != CNT_MAX)
			next_rec_cnt = rec_cnt + 1'b1;
		unique case (state)
			// Loop runs off the local reference until a window ends with signal present
			SRX_REF_TRAIN: begin
				next_lock = 1'b0;
				if (win_end && !los_now)
					next_state = SRX_DATA_ACQ;
			end
			// Trying the incoming data; lock once frequency agrees
			SRX_DATA_ACQ: begin
				if (los_now) begin
					next_state = SRX_REF_TRAIN;
				end else if (win_end && in_tol) begin
					next_state = SRX_LOCKED;
					next_lock  = 1'b1;
				end
			end
			// Locked: losing signal or drifting drops back to reference
			SRX_LOCKED: begin
				if (los_now || (win_end && !in_tol)) begin
					next_state = SRX_REF_TRAIN;
					next_lock  = 1'b0;
				end
			end
		endcase
		// Parallel clock follows recovery only while locked
		next_on_ref = (next_state != SRX_LOCKED);
		next_pclk   = next_on_ref ? ref_s : rec_s;
	end

	// Lock registers; reset lands in reference training
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state   <= SRX_REF_TRAIN;
			lock    <= 1'b0;
			ref_cnt <= '0;
			rec_cnt <= '0;
			los     <= 1'b1;
			pclk    <= 1'b0;
			on_ref  <= 1'b1;
		end else begin
			state   <= next_state;
			lock    <= next_lock;
			ref_cnt <= next_ref_cnt;
			rec_cnt <= next_rec_cnt;
			los     <= next_los;
			pclk    <= next_pclk;
			on_ref  <= next_on_ref;
		end
	end

	assign recovery_lock_out     = lock;
	assign loss_of_signal_state  = los;
	assign rx_parallel_clock_out = pclk;
	assign rx_pclk_on_ref        = on_ref;

	////////////////////////////////////////////////////////////////////
	// Receive buffer: output slot plus a skid slot, so a stall by the
	// framer never drops a word. Muted words are stored as zero.

	logic [WORD_W-1:0] out_d;     // Output slot data
	logic [WORD_W-1:0] next_out_d;
	logic              out_v;
	logic              next_out_v;
	logic [WORD_W-1:0] skid_d;    // Skid slot data
	logic [WORD_W-1:0] next_skid_d;
	logic              skid_v;
	logic              next_skid_v;
	logic              in_rdy;
	logic              mute;
	logic              take;
	logic [WORD_W-1:0] word_in;

	assign mute    = los_now | ~dis_n_s;
	assign take    = rx_serial_valid & in_rdy;
	assign word_in = mute ? WORD_RST : rx_serial_in;

	// Buffer next state
	always_comb begin
		next_out_d  = out_d;
		next_out_v  = out_v;
		next_skid_d = skid_d;
		next_skid_v = skid_v;
		if (rx_parallel_ready || !out_v) begin
			// Output slot frees: skid first keeps word order
			if (skid_v) begin
				next_out_v  = 1'b1;
				next_out_d  = skid_d;
				next_skid_v = 1'b0;
			end else begin
				next_out_v  = take;
				next_out_d  = take ? word_in : out_d;
			end
		end else if (take) begin
			next_skid_v = 1'b1;
			next_skid_d = word_in;
		end
		// Held words are cleared too, for the whole mute
		if (mute) begin
			next_out_d  = WORD_RST;
			next_skid_d = WORD_RST;
		end
	end

	// Output data clears at once when disable goes low, clock or not;
	// the disable pin only ever forces the reset constant here.
	always_ff @(posedge core_clk or negedge rst_b
	            or negedge rx_data_disable_n) begin
		if (!rst_b)
			out_d <= WORD_RST;
		else if (!rx_data_disable_n)
			out_d <= WORD_RST;
		else
			out_d <= next_out_d;
	end

	// Remaining buffer registers; ready is low whenever the skid is full
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_v  <= 1'b0;
			skid_d <= WORD_RST;
			skid_v <= 1'b0;
			in_rdy <= 1'b0;
		end else begin
			out_v  <= next_out_v;
			skid_d <= next_skid_d;
			skid_v <= next_skid_v;
			in_rdy <= ~next_skid_v;
		end
	end

	assign rx_parallel_out   = out_d;
	assign rx_parallel_valid = out_v;
	assign rx_serial_ready   = in_rdy;

	////////////////////////////////////////////////////////////////////
	// Pattern engine

	srx_prbs_if pif ();

	assign pif.en       = pt_s;
	assign pif.clr_n    = clr_s;
	assign pif.rx_valid = take & ~mute;
	assign pif.rx_word  = rx_serial_in;

	srx_prbs u_prbs (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pif      (pif)
	);

	assign pattern_error_flag = pif.err;

	////////////////////////////////////////////////////////////////////
	// Transmit path and loop controls

	logic [WORD_W-1:0] pipe [PIPE_D];  // Fixed latency delay line
	logic [WORD_W-1:0] next_pipe0;
	logic [WORD_W-1:0] tx_out;
	logic              fec_r, sloop, ploop, clean;
	logic              next_sloop, next_ploop, next_clean;

	// Word source: pattern over parallel loop over the framer input
	always_comb begin
		if (pt_s)
			next_pipe0 = pif.gen_word;
		else if (host_s && rlp_s)
			next_pipe0 = out_d;
		else
			next_pipe0 = tx_s;
		// Shared pin: as a clear it cannot also select loopback
		next_sloop = clr_s & ~pt_s;
		next_ploop = host_s & rlp_s;
		next_clean = host_s & rlp_s & dej_s;
	end

	// Delay line: sync (2) + PIPE_D + output flop gives TX_LAT_P
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < PIPE_D; i++)
				pipe[i] <= WORD_RST;
			tx_out <= WORD_RST;
			fec_r  <= 1'b0;
			sloop  <= 1'b0;
			ploop  <= 1'b0;
			clean  <= 1'b0;
		end else begin
			pipe[0] <= next_pipe0;
			for (int i = 1; i < PIPE_D; i++)
				pipe[i] <= pipe[i-1];
			tx_out <= pipe[PIPE_D-1];
			fec_r  <= fec_s;
			sloop  <= next_sloop;
			ploop  <= next_ploop;
			clean  <= next_clean;
		end
	end

	assign tx_serial_out             = tx_out;
	assign tx_rate_fec               = fec_r;
	assign serial_remote_loop_active = sloop;
	assign parallel_loop_active      = ploop;
	assign loop_timing_clean         = clean;
endmodule

// ### verif/srx_top_assertions.sv
// Purpose: Concurrent checks on the ports of the receive control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Pins pass two sync flops, so every bound allows for them.
`timescale 1ns/1ns
module srx_top_assertions
	import srx_pkg::*;
#(
	parameter int TX_LAT_P = TX_LAT_CYC  // Transmit latency in cycles
) (
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire logic [WORD_W-1:0] tx_parallel_in,
	input wire logic [WORD_W-1:0] tx_serial_out,
	input wire logic              tx_rate_fec,
	input wire logic              fec_ref_select,
	input wire logic [WORD_W-1:0] rx_parallel_out,
	input wire logic              rx_data_disable_n,
	input wire logic              loss_of_signal_state,
	input wire logic              recovery_lock_out,
	input wire logic              rx_pclk_on_ref,
	input wire logic              pattern_test_enable,
	input wire logic              pattern_error_clear,
	input wire logic              pattern_error_flag,
	input wire logic              serial_remote_loop_active,
	input wire logic              parallel_loop_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [4:0] thru_cnt;  // Cycles spent in plain through mode
	////////////////////////////////////////////////////////////////////////
	// Saturating count: waits until the whole pipe holds pin data only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) thru_cnt <= 5'h00;
		else if (pattern_test_enable) thru_cnt <= 5'h00;
		else if (parallel_loop_active) thru_cnt <= 5'h00;
		else if (thru_cnt != 5'h1f) thru_cnt <= thru_cnt + 5'h01;
	end
	////////////////////////////////////////////////////////////////////////
	chk_tx_latency: assert property (thru_cnt == 5'h1f |->
		tx_serial_out == $past(tx_parallel_in, TX_LAT_P))
		else $error("through path latency wrong");
	chk_fec_rate: assert property ($stable(fec_ref_select) [*4] |->
		tx_rate_fec == fec_ref_select)
		else $error("rate flag does not follow reference select");
	chk_loop_block: assert property (pattern_test_enable [*4] |->
		!serial_remote_loop_active)
		else $error("serial loop active in pattern test");
	chk_flag_clear: assert property ($fell(pattern_error_flag) |->
		!$past(pattern_error_clear, 2) || !$past(pattern_error_clear, 3)
		|| !$past(pattern_error_clear, 4))
		else $error("pattern flag fell without a clear");
	chk_lock_drop: assert property ($rose(loss_of_signal_state) |->
		##[0:2] !recovery_lock_out)
		else $error("lock held through loss of signal");
	chk_pclk_source: assert property ($rose(recovery_lock_out) |->
		!rx_pclk_on_ref)
		else $error("parallel clock still on reference when locked");
	chk_disable_mute: assert property (!rx_data_disable_n |->
		rx_parallel_out == 16'h0000)
		else $error("output not muted by disable");
	chk_loss_mute: assert property (loss_of_signal_state [*2] |->
		rx_parallel_out == 16'h0000)
		else $error("output not muted on loss of signal");
endmodule

bind srx_top srx_top_assertions #(.TX_LAT_P(TX_LAT_P)) u_srx_top_assertions (
	.core_clk, .rst_b, .tx_parallel_in, .tx_serial_out, .tx_rate_fec,
	.fec_ref_select, .rx_parallel_out, .rx_data_disable_n,
	.loss_of_signal_state, .recovery_lock_out, .rx_pclk_on_ref,
	.pattern_test_enable, .pattern_error_clear, .pattern_error_flag,
	.serial_remote_loop_active, .parallel_loop_active
);

// ### verif/srx_framer_model.sv
// Purpose: Framer on the receive parallel side, taking words.
// Assumes: Same clock as the block; ready changes only at rising edges.
// Notes:   Mode 0 always ready, 1 random stall, 2 never ready.
`timescale 1ns/1ns
module srx_framer_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] stall,
	input  wire logic       rx_parallel_valid,
	output logic            rx_parallel_ready
);
	// Ready is registered, so a stall lands one edge after the request
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) rx_parallel_ready <= 1'b0;
		else if (stall == 2'h0) rx_parallel_ready <= 1'b1;
		else if (stall == 2'h1) rx_parallel_ready <= 1'($urandom);
		else rx_parallel_ready <= 1'b0;
	end
endmodule

// ### verif/srx_top_test.sv
// Purpose: Self-checking bench for the receive control block.
// Assumes: Word-rate clocks are levels stepped on core_clk.
// Notes:   Short lock window keeps the run brief; tolerance is then zero.
`timescale 1ns/1ns
module srx_top_test;
	localparam int WIN = 100;  // Reference edges per lock window
	logic core_clk = 1'b0, rst_b = 1'b0, fast = 1'b0;
	logic [1:0] ph = 2'h0, stall = 2'h0;  // Clock phase, framer mode
	logic [15:0] tx_parallel_in = 16'h0000, rx_serial_in = 16'h0000;
	logic rx_serial_valid = 1'b0, fec_ref_select = 1'b0;
	logic optical_signal_detect_in = 1'b1, signal_detect_polarity = 1'b1;
	logic rx_data_disable_n = 1'b1, pattern_test_enable = 1'b0;
	logic pattern_error_clear = 1'b1, host_mode = 1'b0;
	logic parallel_remote_loop_select = 1'b0, dejitter_loop_timing = 1'b0;
	logic [15:0] tx_serial_out, rx_parallel_out;
	logic tx_rate_fec, rx_serial_ready, rx_parallel_valid, rx_parallel_ready;
	logic rx_parallel_clock_out, rx_pclk_on_ref, loss_of_signal_state;
	logic recovery_lock_out, pattern_error_flag, serial_remote_loop_active;
	logic parallel_loop_active, loop_timing_clean;
	wire ref_clock_a = ph[1];  // Reference edge every four cycles
	wire ref_clock_b = ph[1];
	wire recovered_div_clk = fast ? ph[0] : ph[1];  // Fast: twice the rate
	logic [15:0] exp_q[$];  // Expected receive words, oldest first
	int miscompares = 0, n_checks = 0, cyc = 0, i;

	srx_top #(.FREQ_WIN_P(WIN)) u_srx_top (.core_clk, .rst_b,
		.tx_parallel_in, .tx_serial_out, .tx_rate_fec, .fec_ref_select,
		.rx_serial_in, .rx_serial_valid, .rx_serial_ready, .rx_parallel_out,
		.rx_parallel_valid, .rx_parallel_ready, .rx_parallel_clock_out,
		.rx_pclk_on_ref, .ref_clock_a, .ref_clock_b, .recovered_div_clk,
		.optical_signal_detect_in, .signal_detect_polarity,
		.rx_data_disable_n, .loss_of_signal_state, .recovery_lock_out,
		.pattern_test_enable, .pattern_error_clear, .pattern_error_flag,
		.serial_remote_loop_active, .host_mode, .parallel_remote_loop_select,
		.dejitter_loop_timing, .parallel_loop_active, .loop_timing_clean);
	srx_framer_model u_srx_framer_model (.core_clk, .rst_b, .stall,
		.rx_parallel_valid, .rx_parallel_ready);

	////////////////////////////////////////////////////////////////////////
	// Clock, word-rate levels, transmit pin traffic and the hang guard
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) ph <= ph + 2'h1;
	always @(posedge core_clk) tx_parallel_in <= 16'($urandom);
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			$display("ERROR timeout expected done seen hang");
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic cmp_bit(input string n, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic cmp_word(input string n, input logic [15:0] e,
		input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// Holds the word until ready is seen, so a refused word is retried
	task automatic send(input logic [15:0] w, input logic m);
		rx_serial_in <= w;
		rx_serial_valid <= 1'b1;
		exp_q.push_back(m ? 16'h0000 : w);
		@(negedge core_clk);
		while (rx_serial_ready !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
	endtask
	task automatic drain();
		rx_serial_valid <= 1'b0;
		for (int j = 0; j < 300 && exp_q.size() != 0; j++) @(posedge core_clk);
		cmp_bit("drained", 1'b1, exp_q.size() == 0);
	endtask
	task automatic wait_lock(input logic v, input int n);
		for (int j = 0; j < n && recovery_lock_out !== v; j++)
			@(posedge core_clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Every word the framer takes is matched against the oldest note
	always @(posedge core_clk) begin
		if (rx_parallel_valid === 1'b1 && rx_parallel_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("ERROR rx_extra expected none seen %h", rx_parallel_out);
			end
			else cmp_word("rx_word", exp_q.pop_front(), rx_parallel_out);
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h95a6));
		repeat (10) @(posedge core_clk);
		cmp_bit("los_rst", 1'b1, loss_of_signal_state);
		cmp_bit("flag_rst", 1'b1, pattern_error_flag);
		cmp_bit("pclk_rst", 1'b1, rx_pclk_on_ref);
		rst_b <= 1'b1;
		for (i = 0; i < 4; i++) begin
			{optical_signal_detect_in, signal_detect_polarity} <= 2'(i);
			repeat (5) @(posedge core_clk);
			cmp_bit("los", i[1] ^ i[0], loss_of_signal_state);
		end
		$display("test polarity done");
		for (i = 0; i < 8; i++) begin
			{host_mode, parallel_remote_loop_select} <= 2'(i >> 1);
			dejitter_loop_timing <= i[0];
			{pattern_error_clear, pattern_test_enable} <= 2'(i);
			fec_ref_select <= i[0];
			repeat (5) @(posedge core_clk);
			cmp_bit("ploop", i[2] & i[1], parallel_loop_active);
			cmp_bit("clean", i[2] & i[1] & i[0], loop_timing_clean);
			cmp_bit("sloop", i[1] & ~i[0], serial_remote_loop_active);
			cmp_bit("fec", i[0], tx_rate_fec);
		end
		{host_mode, parallel_remote_loop_select} <= 2'h0;
		{pattern_error_clear, pattern_test_enable, fec_ref_select} <= 3'h4;
		$display("test modes done");
		wait_lock(1'b1, 1500);
		cmp_bit("lock_first", 1'b1, recovery_lock_out);
		cmp_bit("pclk_rec", ph[1] ^ ph[0], rx_parallel_clock_out);
		fast <= 1'b1;
		wait_lock(1'b0, 900);
		cmp_bit("lock_ppm", 1'b0, recovery_lock_out);
		fast <= 1'b0;
		wait_lock(1'b1, 1500);
		cmp_bit("relock", 1'b1, recovery_lock_out);
		optical_signal_detect_in <= 1'b0;
		wait_lock(1'b0, 5);
		cmp_bit("lock_sd", 1'b0, recovery_lock_out);
		cmp_bit("pclk_ref", 1'b1, rx_pclk_on_ref);
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 3; i++) send(16'($urandom), 1'b1);
		drain();
		optical_signal_detect_in <= 1'b1;
		wait_lock(1'b1, 1500);
		cmp_bit("relock_sd", 1'b1, recovery_lock_out);
		$display("test lock done");
		stall <= 2'h2;
		send(16'($urandom), 1'b0);
		send(16'($urandom), 1'b0);
		rx_serial_valid <= 1'b0;
		@(negedge core_clk);
		cmp_bit("refused", 1'b0, rx_serial_ready);
		@(posedge core_clk);
		stall <= 2'h1;
		for (i = 0; i < 40; i++) send(16'($urandom), 1'b0);
		drain();
		stall <= 2'h2;
		send(16'($urandom), 1'b1);
		rx_serial_valid <= 1'b0;
		rx_data_disable_n <= 1'b0;
		#1 cmp_word("mute_async", 16'h0000, rx_parallel_out);
		@(posedge core_clk);
		stall <= 2'h0;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 3; i++) send(16'($urandom), 1'b1);
		drain();
		rx_data_disable_n <= 1'b1;
		$display("test stream done");
		pattern_test_enable <= 1'b1;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < 62; i++) begin
			if (i == 40) cmp_bit("flag_latch", 1'b1, pattern_error_flag);
			if (i == 42) pattern_error_clear <= 1'b0;
			if (i == 48) pattern_error_clear <= 1'b1;
			if (i == 56) cmp_bit("flag_sync", 1'b0, pattern_error_flag);
			send(i == 58 ? ~tx_serial_out : tx_serial_out, 1'b0);
		end
		drain();
		cmp_bit("flag_err", 1'b1, pattern_error_flag);
		$display("test pattern done");
		end_of_test();
	end
endmodule
